/* hdl/bpsc_pkg.sv */
// Behaviour
// - reset forces counter, capture, control idle
// - busy rises, one bit per clock
// - serial clock is inverted clock gated
// - strobe captured, synchronised before transfer
// - three-bit counter marks the last bit
// - count n selects parallel bit n
// - counter advances by one when permitted
// - busy rises on falling edge after strobe
// - active flag sets after busy, clears at seven
// - serial data low while not active
// - counter holds unless transfer active
package bpsc_pkg;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
endpackage

/* hdl/bpsc_converter.sv */
`timescale 1ns/1ps
module bpsc_converter
  import bpsc_pkg::*;
#(
  parameter int DATA_W = BYTE_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] parallel_in_byte,
  output logic busy,
  output logic serial_data_out,
  output logic serial_clk_out
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (DATA_W != (1 << CNT_W)) begin : g_bad_width
    $error("DATA_W must equal two to the counter width");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic rstMeta_r;
  logic rstSync_n;

  // release lands on a rising edge for every flop on rstSync_n; the strobe toggle and these two flops take reset_n directly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'h0;
      rstSync_n <= 1'h0;
    end else begin
      rstMeta_r <= 1'h1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ****************************************
  // strobe capture
  // ****************************************
  // a toggle survives any strobe width, even shorter than a clock
  logic strobeTgl_r;
  logic strobeTgl_nxt;
  logic tglMeta_r;
  logic tglSync_r;
  logic tglSeen_r;
  // byte is not latched: the host must hold it for the whole burst
  logic [DATA_W-1:0] byteMeta_r;
  logic [DATA_W-1:0] byteSync_r;
  logic strobeEvt;

  always_comb begin
    strobeTgl_nxt = ~strobeTgl_r;
  end

  always_ff @(negedge write_strobe_n or negedge reset_n) begin
    if (!reset_n) begin
      strobeTgl_r <= 1'h0;
    end else begin
      strobeTgl_r <= strobeTgl_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      tglMeta_r <= 1'h0;
      tglSync_r <= 1'h0;
      tglSeen_r <= 1'h0;
      byteMeta_r <= BYTE_RESET;
      byteSync_r <= BYTE_RESET;
    end else begin
      tglMeta_r <= strobeTgl_r;
      tglSync_r <= tglMeta_r;
      tglSeen_r <= tglSync_r;
      byteMeta_r <= parallel_in_byte;
      byteSync_r <= byteMeta_r;
    end
  end

  assign strobeEvt = tglSync_r ^ tglSeen_r;

  // ****************************************
  // transfer control
  // ****************************************
  logic pending_r;
  logic pending_nxt;
  logic gate_r;
  logic gate_nxt;
  logic done_r;
  logic done_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic serialData_r;
  logic serialData_nxt;
  logic busy_r;
  logic busy_nxt;
  logic lastBit;

  assign lastBit = gate_r && (count_r == CNT_LAST);

  always_comb begin
    // only one queued strobe is kept; later ones merge into it
    // request seen, set wins over start clear
    pending_nxt = strobeEvt | (pending_r & ~(busy_r & ~gate_r));
    // active after busy, ends at seven
    gate_nxt = busy_r & ~lastBit & ~done_r;
    done_nxt = lastBit;
    count_nxt = count_r;
    if (gate_r) begin
      count_nxt = count_r + CNT_STEP;
    end
    // count selects bit; low when idle
    serialData_nxt = gate_nxt & byteSync_r[count_nxt];
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pending_r <= 1'h0;
      gate_r <= 1'h0;
      done_r <= 1'h0;
      count_r <= CNT_RESET;
      serialData_r <= 1'h0;
    end else begin
      pending_r <= pending_nxt;
      gate_r <= gate_nxt;
      done_r <= done_nxt;
      count_r <= count_nxt;
      serialData_r <= serialData_nxt;
    end
  end

  // ****************************************
  // busy flag, falling edge
  // ****************************************
  // falling edge lets busy lead the first bit by half a cycle
  always_comb begin
    // rise on falling edge; drop after last bit
    busy_nxt = busy_r;
    if (pending_r) begin
      busy_nxt = 1'h1;
    end else if (done_r) begin
      busy_nxt = 1'h0;
    end
  end

  always_ff @(negedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      busy_r <= 1'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy = busy_r;
  assign serial_data_out = serialData_r;
  // not a flop: it is a gated copy of the clock itself
  // gated inverted clock, glitch free since gate moves on rising edge
  assign serial_clk_out = ~clk & gate_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);
  // busy moves half a cycle ahead of the rising-edge state it guards

  // three-bit counter, so a burst is always eight clocks
  sequence burstS;
    gate_r [*8] ##1 !gate_r;
  endsequence

  sequence startS;
    $rose(gate_r) && (count_r == CNT_RESET);
  endsequence

  burst_len_a: assert property (startS |-> burstS)
    else $error("transfer not eight bits long");
  gate_cause_a: assert property ($rose(gate_r) |-> $past(busy_r))
    else $error("active without busy");
  count_hold_a: assert property (!gate_r |=> $stable(count_r))
    else $error("counter moved while idle");
  count_step_a: assert property (gate_r && !lastBit |=> count_r == $past(count_r) + CNT_STEP)
    else $error("counter step wrong");
  count_wrap_a: assert property (lastBit |=> count_r == CNT_RESET && !gate_r)
    else $error("no wrap at seven");
  data_mux_a: assert property (serialData_r == (gate_r & byteSync_r[count_r]))
    else $error("serial bit mismatch");
  data_idle_a: assert property (!gate_r |-> !serialData_r)
    else $error("data high while idle");
  busy_rise_a: assert property ($rose(pending_r) |-> busy_r)
    else $error("busy late after strobe");
  busy_end_a: assert property ($fell(gate_r) && !pending_r |=> !busy_r ##1 !gate_r)
    else $error("no return to idle");
  strobe_take_a: assert property (strobeEvt |=> pending_r)
    else $error("strobe lost");

  sequence settleS;
    !gate_r && !pending_r;
  endsequence

  busy_hold_a: assert property (gate_r |-> busy_r)
    else $error("busy low while sending");
  gate_start_a: assert property ($rose(gate_r) |-> count_r == CNT_RESET)
    else $error("transfer not from bit zero");
  done_pulse_a: assert property (done_r |=> !done_r)
    else $error("end marker stuck");
  busy_fall_a: assert property ($fell(busy_r) |-> settleS)
    else $error("busy fell mid transfer");
  pend_hold_a: assert property (pending_r && gate_r |=> pending_r)
    else $error("queued strobe lost");
endmodule

/* verification/bpsc_receiver.sv */
`timescale 1ns/1ps
// ****
// serial receiver
// ****
module bpsc_receiver (
  input wire logic reset_n,
  input wire logic serial_clk_out,
  input wire logic serial_data_out,
  output logic [7:0] rxByte,
  output logic [7:0] rxCount
);
  always_ff @(posedge serial_clk_out or negedge reset_n) begin
    if (!reset_n) begin
      rxByte <= 8'h00;
      rxCount <= 8'h00;
    end else begin
      rxByte <= {serial_data_out, rxByte[7:1]};
      rxCount <= rxCount + 8'h01;
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
  import bpsc_pkg::*;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic write_strobe_n = 1'h1;
  logic [7:0] parallel_in_byte = 8'h00;
  logic busy, serial_data_out, serial_clk_out;
  logic [7:0] rxByte, rxCount;
  int failures = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  bpsc_converter DUT (.clk(clk), .reset_n(reset_n), .write_strobe_n(write_strobe_n),
    .parallel_in_byte(parallel_in_byte), .busy(busy),
    .serial_data_out(serial_data_out), .serial_clk_out(serial_clk_out));
  bpsc_receiver RX (.reset_n(reset_n), .serial_clk_out(serial_clk_out),
    .serial_data_out(serial_data_out), .rxByte(rxByte), .rxCount(rxCount));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic idle();
    @(negedge clk);
    #1;
    check("sdo", 8'h00, {7'h00, serial_data_out});
    check("sclk", 8'h00, {7'h00, serial_clk_out});
    check("busy", 8'h00, {7'h00, busy});
  endtask
  // byte first, strobe three clocks later
  task automatic pulse(logic [7:0] b);
    @(posedge clk);
    parallel_in_byte <= b;
    repeat (3) @(posedge clk);
    write_strobe_n <= 1'h0;
    @(posedge clk);
    write_strobe_n <= 1'h1;
  endtask
  task automatic send(logic [7:0] b);
    int n;
    logic [7:0] c0;
    c0 = rxCount;
    pulse(b);
    n = 0;
    while (busy !== 1'h1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    check("busy up", 8'h01, {7'h00, busy});
    n = 0;
    while (busy !== 1'h0 && n < 16) begin
      @(posedge clk);
      n++;
    end
    check("byte", b, rxByte);
    check("bits", 8'h08, rxCount - c0);
    idle();
  endtask
  task automatic testReset();
    idle();
    check("rx", 8'h00, rxCount);
  endtask
  task automatic testSingle();
    send(8'hA5);
  endtask
  // back to back, counter restarts at bit0
  task automatic testBack();
    send(8'h01);
    send(8'h80);
    send(8'hFF);
    send(8'h00);
  endtask
  // second strobe while sending is kept and replays the byte
  task automatic testQueue();
    logic [7:0] c0;
    c0 = rxCount;
    pulse(8'h5A);
    repeat (5) @(posedge clk);
    write_strobe_n <= 1'h0;
    @(posedge clk);
    write_strobe_n <= 1'h1;
    repeat (30) @(posedge clk);
    check("queued bits", 8'h10, rxCount - c0);
    check("queued byte", 8'h5A, rxByte);
    idle();
  endtask
  // reset in mid transfer, then a clean restart from bit0
  task automatic testMidReset();
    pulse(8'h3C);
    repeat (6) @(posedge clk);
    check("busy mid", 8'h01, {7'h00, busy});
    reset_n <= 1'h0;
    repeat (8) @(posedge clk);
    idle();
    check("rx", 8'h00, rxCount);
    @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk);
    idle();
    send(8'h3C);
  endtask
  initial begin
    #20000;
    failures++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk);
    testReset();
    testSingle();
    testBack();
    testQueue();
    testMidReset();
    results();
  end
endmodule
